/* File: hw/vpic_pkg.sv */
// shared constants for the vectored priority interrupt controller
package vpic_pkg;
  localparam int          NUM_SRC      = 24;
  localparam int          NUM_GRP      = 3;
  localparam logic [11:0] REQ0_OFS     = 12'hFC0;
  localparam logic [11:0] HI_REL_OFS   = 12'h001;
  localparam logic [11:0] LO_REL_OFS   = 12'h002;
  localparam logic [11:0] GRP_STRIDE   = 12'h003;
  localparam logic [11:0] EDGE_SEL_OFS = 12'hFCD;
  localparam logic [11:0] PORT_SEL_OFS = 12'hFCE;
  localparam logic [11:0] CTRL_OFS     = 12'hFCF;
  localparam int          GATE_BIT     = 7;
  localparam logic [7:0]  REQ_RST      = 8'h00;
  localparam logic [7:0]  EN_RST       = 8'h00;
  localparam logic [7:0]  SEL_RST      = 8'h00;
  localparam logic [7:0]  RD_UNMAPPED  = 8'h00;
  localparam logic [15:0] VEC_RESET    = 16'h0002;
  localparam logic [15:0] VEC_WDT      = 16'h0004;
  localparam logic [15:0] VEC_ILLEGAL  = 16'h0006;
  localparam logic [15:0] VEC_BASE     = 16'h0008;
  localparam logic [15:0] VEC_LAST     = 16'h0036;
  localparam logic [1:0]  LVL_OFF      = 2'h0;
  localparam logic [1:0]  LVL_1        = 2'h1;
  localparam logic [1:0]  LVL_2        = 2'h2;
  localparam logic [1:0]  LVL_3        = 2'h3;
endpackage

/* File: hw/vpic_ctrl.sv */
// vectored priority interrupt controller with request latches and register port
// Operation
// [RULE_01] 24 vectors: 12 pin, 12 peripheral sources
// [RULE_02] vector word: high byte even, low odd
// [RULE_03] vectors 0002H..0036H, table order is priority
// [RULE_04] watchdog 0004H, illegal trap 0006H, not interrupt
// [RULE_05] eight peripherals on 0008H..0016H in order
// [RULE_06] shared pins 7..0 on 0018H..0026H, edge select
// [RULE_07] timer3, uart1 rx/tx, dma on 0028H..002EH
// [RULE_08] four dual-edge pins on 0030H..0036H
// [RULE_09] master gate bit written 1/0 enables/disables
// [RULE_10] enable and return instructions set gate
// [RULE_11] disable, ack, reset, traps clear gate
// [RULE_12] level 3 beats 2, 2 beats 1
// [RULE_13] same level: lower vector wins
// [RULE_14] watchdog and traps outrank programmable interrupts
// [RULE_15] one-cycle source pulse sets request bit
// [RULE_16] acknowledge clears the winning request bit
// [RULE_17] software write 0 clears, 1 sets request
// [RULE_18] software uses atomic read-modify-write on requests
// [RULE_19] gate set forwards winner, else polling only
// [RULE_20] enables never alter request register reads
// [RULE_21] request_latch_0 bits: t2..adc, rw, reset 0
// [RULE_22] watchdog is controlled outside these registers
// [RULE_23] high/low bit pair sets level or off
// [RULE_24] port select picks one shared pin source
// [RULE_25] disabled pending request stays latched, unforwarded
// [RULE_26] vector supplied in cycle request bit clears
`timescale 1ns/10ps
module vpic_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [7:0]  periph0_pulse,
  input  wire logic [3:0]  periph2_pulse,
  input  wire logic [7:0]  pin_port_a,
  input  wire logic [7:0]  pin_port_d,
  input  wire logic [3:0]  pin_port_c,
  input  wire logic        wdt_irq,
  input  wire logic        enable_irq_instruction,
  input  wire logic        disable_irq_instruction,
  input  wire logic        return_from_irq_instruction,
  input  wire logic        cpu_trap,
  input  wire logic        cpu_illegal_trap,
  input  wire logic        cpu_ack,
  output logic             irq_pending,
  output logic      [15:0] irq_vector,
  output logic             master_irq_gate
);
  import vpic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [23:0] req_q, req_d, pulse_vec;
  logic [23:0] hi_q, lo_q;
  logic [7:0]  edge_sel_q, port_sel_q;
  logic [7:0]  shared_prev_q;
  logic [3:0]  dual_prev_q;
  logic        prime_q;
  logic        gate_q;
  logic        win_valid_q, wdt_win_q;
  logic [4:0]  win_pos_q;
  logic [15:0] vector_q;
  logic [7:0]  rdata_q;
  logic [7:0]  shared_pin, shared_edge;
  logic [3:0]  dual_edge;
  logic [4:0]  best_pos, cand_pos;
  logic [4:0]  best_idx;
  logic [1:0]  best_lvl, cand_lvl;
  logic        best_any;
  logic        gate_clr, gate_set;
  logic        ack_take;
  logic [7:0]  rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // pin edge detection
  assign shared_pin = (port_sel_q & pin_port_d) | (~port_sel_q & pin_port_a);  // [RULE_24]
  // edge_sel bit 1 picks falling edge, 0 rising
  assign shared_edge = prime_q ? ((shared_pin & ~shared_prev_q & ~edge_sel_q)
                     | (~shared_pin & shared_prev_q & edge_sel_q)) : 8'h00;  // [RULE_06]
  assign dual_edge = prime_q ? (pin_port_c ^ dual_prev_q) : 4'h0;  // [RULE_08]

  // first cycle after reset is not an edge: prev values are not yet real
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shared_prev_q <= 8'h00;
      dual_prev_q   <= 4'h0;
      prime_q       <= 1'b0;
    end else begin
      shared_prev_q <= shared_pin;
      dual_prev_q   <= pin_port_c;
      prime_q       <= 1'b1;
    end
  end

  // group 0 peripherals, group 1 shared pins, group 2 late peripherals + dual pins
  assign pulse_vec = {periph2_pulse, dual_edge, shared_edge, periph0_pulse};  // [RULE_01]

  ////////////////////////////////////////////////////////////////////////////
  // request latches, one per source
  assign ack_take = cpu_ack && irq_pending && win_valid_q && !wdt_win_q;

  generate
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_req
      localparam logic [11:0] OFS = REQ0_OFS + GRP_STRIDE * 12'(g / 8);
      always_comb begin
        req_d[g] = req_q[g];
        if (ack_take && win_pos_q == 5'(g)) begin
          req_d[g] = 1'b0;  // [RULE_16]
        end
        if (reg_wr && reg_addr == OFS) begin
          req_d[g] = reg_wdata[g % 8];  // [RULE_17]
        end
        // a source pulse wins over any clear in the same cycle
        if (pulse_vec[g]) begin
          req_d[g] = 1'b1;  // [RULE_15]
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      req_q <= {REQ_RST, REQ_RST, REQ_RST};  // [RULE_21]
    end else begin
      req_q <= req_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hi_q       <= {EN_RST, EN_RST, EN_RST};
      lo_q       <= {EN_RST, EN_RST, EN_RST};
      edge_sel_q <= SEL_RST;
      port_sel_q <= SEL_RST;
    end else if (reg_wr) begin
      for (int k = 0; k < NUM_GRP; k++) begin
        if (reg_addr == REQ0_OFS + GRP_STRIDE * 12'(k) + HI_REL_OFS) begin
          hi_q[k*8 +: 8] <= reg_wdata;  // [RULE_23]
        end
        if (reg_addr == REQ0_OFS + GRP_STRIDE * 12'(k) + LO_REL_OFS) begin
          lo_q[k*8 +: 8] <= reg_wdata;  // [RULE_23]
        end
      end
      if (reg_addr == EDGE_SEL_OFS) begin
        edge_sel_q <= reg_wdata;
      end
      if (reg_addr == PORT_SEL_OFS) begin
        port_sel_q <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master gate
  assign gate_clr = disable_irq_instruction || ack_take || (cpu_ack && wdt_win_q)
                  || cpu_trap || cpu_illegal_trap
                  || (reg_wr && reg_addr == CTRL_OFS && !reg_wdata[GATE_BIT]);  // [RULE_11]
  assign gate_set = enable_irq_instruction || return_from_irq_instruction
                  || (reg_wr && reg_addr == CTRL_OFS && reg_wdata[GATE_BIT]);  // [RULE_10]

  // a disabling event beats an enabling one so a trap cannot be re-entered
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      gate_q <= 1'b0;  // [RULE_11]
    end else if (gate_clr) begin
      gate_q <= 1'b0;  // [RULE_09]
    end else if (gate_set) begin
      gate_q <= 1'b1;  // [RULE_09]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration, scanned lowest priority first so later hits override
  always_comb begin
    best_idx = 5'h00;
    best_pos = 5'h00;
    best_lvl = LVL_OFF;
    best_any = 1'b0;
    cand_pos = 5'h00;
    cand_lvl = LVL_OFF;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      // table index i maps to bit 7-(i%8) of group i/8
      cand_pos = 5'(8 * (i / 8) + 7 - (i % 8));  // [RULE_05] [RULE_07]
      cand_lvl = {hi_q[cand_pos], lo_q[cand_pos]};
      // off-level requests stay latched but never win
      if (req_d[cand_pos] && cand_lvl != LVL_OFF && cand_lvl >= best_lvl) begin  // [RULE_25]
        best_idx = 5'(i);  // [RULE_13]
        best_pos = cand_pos;
        best_lvl = cand_lvl;  // [RULE_12]
        best_any = 1'b1;
      end
    end
  end

  // watchdog is enabled elsewhere; here it only outranks everything
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      win_valid_q <= 1'b0;
      wdt_win_q   <= 1'b0;
      win_pos_q   <= 5'h00;
      vector_q    <= VEC_RESET;
    end else begin
      win_valid_q <= best_any || wdt_irq;
      wdt_win_q   <= wdt_irq;  // [RULE_14] [RULE_22]
      win_pos_q   <= best_pos;
      if (wdt_irq) begin
        vector_q <= VEC_WDT;  // [RULE_04]
      end else begin
        // each entry is a two-byte word, so the step is two
        vector_q <= VEC_BASE + {10'h000, best_idx, 1'b0};  // [RULE_02] [RULE_03]
      end
    end
  end

  // vector stays valid during the acknowledge cycle itself
  assign irq_pending     = gate_q && win_valid_q;  // [RULE_19]
  assign irq_vector      = vector_q;  // [RULE_26]
  assign master_irq_gate = gate_q;

  ////////////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after the strobe
  always_comb begin
    rd_mux = RD_UNMAPPED;
    for (int k = 0; k < NUM_GRP; k++) begin
      if (reg_addr == REQ0_OFS + GRP_STRIDE * 12'(k)) begin
        rd_mux = req_q[k*8 +: 8];  // [RULE_20]
      end
      if (reg_addr == REQ0_OFS + GRP_STRIDE * 12'(k) + HI_REL_OFS) begin
        rd_mux = hi_q[k*8 +: 8];
      end
      if (reg_addr == REQ0_OFS + GRP_STRIDE * 12'(k) + LO_REL_OFS) begin
        rd_mux = lo_q[k*8 +: 8];
      end
    end
    if (reg_addr == EDGE_SEL_OFS) begin
      rd_mux = edge_sel_q;
    end
    if (reg_addr == PORT_SEL_OFS) begin
      rd_mux = port_sel_q;
    end
    if (reg_addr == CTRL_OFS) begin
      rd_mux = {gate_q, 7'h00};
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  ack_clears_a: assert property (ack_take && !pulse_vec[win_pos_q] && !reg_wr  // [RULE_16]
    |=> !req_q[$past(win_pos_q)])
    else $error("acknowledged request bit not cleared");

  gate_off_a: assert property (  // [RULE_11]
    ((cpu_ack && irq_pending) || disable_irq_instruction || cpu_trap || cpu_illegal_trap)
    |=> !gate_q ##1 !irq_pending)
    else $error("master gate not cleared");

  gate_on_a: assert property (  // [RULE_10]
    (enable_irq_instruction || return_from_irq_instruction) && !gate_clr |=> gate_q)
    else $error("master gate not set");

  poll_only_a: assert property (!gate_q |-> !irq_pending)  // [RULE_19]
    else $error("request forwarded while gate clear");

  pulse_latch_a: assert property (pulse_vec[3] |=> req_q[3])  // [RULE_15]
    else $error("source pulse not latched");

  sw_write_a: assert property (  // [RULE_17]
    reg_wr && reg_addr == REQ0_OFS && periph0_pulse == 8'h00
    |=> req_q[7:0] == $past(reg_wdata))
    else $error("software write to requests lost");

  poll_read_a: assert property (reg_rd && reg_addr == REQ0_OFS  // [RULE_20]
    |=> reg_rdata == $past(req_q[7:0]))
    else $error("request read does not match latch");

  wdt_first_a: assert property ($past(wdt_irq) |-> irq_vector == VEC_WDT)  // [RULE_14]
    else $error("watchdog did not win");

  vec_range_a: assert property (irq_pending && !wdt_win_q  // [RULE_03]
    |-> irq_vector >= VEC_BASE && irq_vector <= VEC_LAST && !irq_vector[0])
    else $error("vector outside table");

  top_level_a: assert property (  // [RULE_12]
    req_d[7] && hi_q[7] && lo_q[7] && !wdt_irq |=> irq_vector == VEC_BASE)
    else $error("level three timer two lost arbitration");

  ack_cov: cover property (irq_pending && cpu_ack);
  wdt_cov: cover property (wdt_irq ##1 irq_pending);
  pin_cov: cover property (shared_edge != 8'h00 ##1 req_q[15:8] != 8'h00);
  race_cov: cover property (ack_take && pulse_vec[win_pos_q]);
  level_cov: cover property (req_d[0] && req_d[7] && hi_q[0] && !hi_q[7]);

  ////////////////////////////////////////////////////////////////////////////
  // edge, register and vector checks
  pin_edge_a: assert property (shared_edge[7] |=> req_q[15])  // [RULE_06]
    else $error("shared pin edge not latched");

  dual_edge_a: assert property (dual_edge[0] |=> req_q[16])  // [RULE_08]
    else $error("dual edge pin not latched");

  edge_prime_a: assert property (!prime_q |-> shared_edge == 8'h00 && dual_edge == 4'h0)  // [RULE_06]
    else $error("false pin edge after reset");

  port_pick_a: assert property (port_sel_q[7] |-> shared_pin[7] == pin_port_d[7])  // [RULE_24]
    else $error("port select ignored");

  gate_write1_a: assert property (  // [RULE_09]
    reg_wr && reg_addr == CTRL_OFS && reg_wdata[GATE_BIT] && !gate_clr |=> gate_q)
    else $error("gate write one lost");

  gate_write0_a: assert property (  // [RULE_09]
    reg_wr && reg_addr == CTRL_OFS && !reg_wdata[GATE_BIT] |=> !gate_q)
    else $error("gate write zero lost");

  no_trap_vec_a: assert property (  // [RULE_04]
    irq_pending |-> irq_vector != VEC_ILLEGAL && irq_vector != VEC_RESET)
    else $error("trap vector offered as interrupt");

  level_order_a: assert property (  // [RULE_12]
    req_d[0] && hi_q[0] && lo_q[0] && req_d[7] && !hi_q[7] && lo_q[7] && !wdt_irq
    |=> irq_vector == VEC_BASE + 16'h000E)
    else $error("level three lost to level one");

  vec_even_a: assert property (win_valid_q |-> !vector_q[0])  // [RULE_02]
    else $error("vector not on word boundary");

  rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))  // [RULE_20]
    else $error("read data changed without read");

  hi_write_a: assert property (reg_wr && reg_addr == REQ0_OFS + HI_REL_OFS  // [RULE_23]
    |=> hi_q[7:0] == $past(reg_wdata))
    else $error("high priority bits not written");

  lo_write_a: assert property (reg_wr && reg_addr == REQ0_OFS + LO_REL_OFS  // [RULE_23]
    |=> lo_q[7:0] == $past(reg_wdata))
    else $error("low priority bits not written");

  sel_write_a: assert property (reg_wr && reg_addr == PORT_SEL_OFS  // [RULE_24]
    |=> port_sel_q == $past(reg_wdata))
    else $error("port select not written");

  edge_write_a: assert property (reg_wr && reg_addr == EDGE_SEL_OFS  // [RULE_06]
    |=> edge_sel_q == $past(reg_wdata))
    else $error("edge select not written");

  ack_drop_a: assert property (ack_take |=> !irq_pending)  // [RULE_11]
    else $error("request still offered after acknowledge");

  // watchdog service must not consume a latched request
  wdt_keep_a: assert property (  // [RULE_22]
    cpu_ack && wdt_win_q && !reg_wr && pulse_vec == 24'h000000 |=> req_q == $past(req_q))
    else $error("watchdog acknowledge cleared a request");
endmodule

/* File: tb/vpic_cpu_model.sv */
// cpu core stand-in that acknowledges forwarded requests
`timescale 1ns/10ps
module vpic_cpu_model (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        irq_pending,
  input  wire logic [15:0] irq_vector,
  input  wire logic [3:0]  ack_dly,
  output logic             cpu_ack,
  output logic      [15:0] taken_vec,
  output int               ack_cnt
);
  logic [3:0] wait_q;
  ////////////////////////////////////////
  // slow core waits ack_dly pending cycles before it answers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_ack <= 1'b0;
      wait_q <= 4'h0;
      taken_vec <= 16'h0000;
      ack_cnt <= 0;
    end else if (cpu_ack) begin
      cpu_ack <= 1'b0;
      wait_q <= 4'h0;
      taken_vec <= irq_vector;
      ack_cnt <= ack_cnt + 1;
    end else if (irq_pending && wait_q >= ack_dly) begin
      cpu_ack <= 1'b1;
    end else begin
      wait_q <= irq_pending ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule

/* File: tb/vpic_ctrl_test.sv */
// self-checking bench for the vectored priority interrupt controller
`timescale 1ns/10ps
module vpic_ctrl_test;
  import vpic_pkg::*;
  logic        sys_clk, resetn, reg_wr, reg_rd, wdt_irq, cpu_ack, irq_pending, master_irq_gate;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, periph0_pulse, pin_port_a, pin_port_d;
  logic [3:0]  periph2_pulse, pin_port_c, ack_dly;
  logic [4:0]  ins;
  logic [15:0] irq_vector, taken_vec;
  int          ack_cnt, error_cnt, check_count, cyc;
  vpic_ctrl i_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .periph0_pulse(periph0_pulse), .periph2_pulse(periph2_pulse), .pin_port_a(pin_port_a),
    .pin_port_d(pin_port_d), .pin_port_c(pin_port_c), .wdt_irq(wdt_irq),
    .enable_irq_instruction(ins[0]), .return_from_irq_instruction(ins[1]),
    .disable_irq_instruction(ins[2]), .cpu_trap(ins[3]), .cpu_illegal_trap(ins[4]),
    .cpu_ack(cpu_ack), .irq_pending(irq_pending), .irq_vector(irq_vector),
    .master_irq_gate(master_irq_gate));
  vpic_cpu_model i_cpu (.sys_clk(sys_clk), .resetn(resetn), .irq_pending(irq_pending),
    .irq_vector(irq_vector), .ack_dly(ack_dly), .cpu_ack(cpu_ack), .taken_vec(taken_vec),
    .ack_cnt(ack_cnt));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      close_out();
    end
  end
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] got);
    check_count++;
    if (got !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task automatic pi(int k);
    @(posedge sys_clk);
    ins <= 5'h01 << k;
    @(posedge sys_clk);
    ins <= 5'h00;
    #1;
  endtask
  task automatic src(logic [7:0] p0, logic [3:0] p2);
    @(posedge sys_clk);
    periph0_pulse <= p0;
    periph2_pulse <= p2;
    @(posedge sys_clk);
    periph0_pulse <= 8'h00;
    periph2_pulse <= 4'h0;
  endtask
  // reopen the gate, wait for the core to take one vector
  task automatic svc(logic [15:0] e);
    int n;
    n = ack_cnt;
    pi(1);
    for (int i = 0; i < 40 && ack_cnt == n; i++) @(posedge sys_clk);
    #1 chk("irq_vector", e, taken_vec);
    chk("master_irq_gate", 1'b0, master_irq_gate);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    logic [11:0] a [4] = '{12'hFC0, 12'hFC1, 12'hFCF, 12'hFC9};
    foreach (a[i]) rd(a[i], 8'h00);
    chk("irq_pending", 1'b0, irq_pending);
  endtask
  task automatic t_poll();
    src(8'h81, 4'h0);
    rd(12'hFC0, 8'h81);
    chk("irq_pending", 1'b0, irq_pending);
    wr(12'hFC0, 8'h00);
    rd(12'hFC0, 8'h00);
    wr(12'hFC0, 8'h24);
    rd(12'hFC0, 8'h24);
    wr(12'hFC0, 8'h00);
  endtask
  task automatic t_prio();
    wr(12'hFC1, 8'h01);
    wr(12'hFC2, 8'h81);
    src(8'h89, 4'h0);
    svc(16'h0016);
    rd(12'hFC0, 8'h88);
    ack_dly <= 4'h3;
    svc(16'h0008);
    wr(12'hFC8, 8'hFF);
    src(8'h00, 4'h9);
    svc(16'h0028);
    svc(16'h002E);
    pi(1);
    repeat (4) @(posedge sys_clk);
    chk("irq_pending", 1'b0, irq_pending);
    rd(12'hFC0, 8'h08);
  endtask
  // port d selected for pin 7, falling edge only; port a toggles unheard
  task automatic t_pins();
    wr(12'hFC5, 8'hFF);
    wr(12'hFCD, 8'h80);
    wr(12'hFCE, 8'h80);
    pi(2);
    pin_port_a <= 8'h80;
    pin_port_d <= 8'h80;
    pin_port_c <= 4'h1;
    @(posedge sys_clk);
    pin_port_a <= 8'h00;
    repeat (2) @(posedge sys_clk);
    rd(12'hFC3, 8'h00);
    rd(12'hFC6, 8'h01);
    pin_port_d <= 8'h00;
    svc(16'h0018);
    svc(16'h0036);
    pin_port_c <= 4'h0;
    svc(16'h0036);
  endtask
  task automatic t_gate();
    wr(12'hFCF, 8'h80);
    chk("master_irq_gate", 1'b1, master_irq_gate);
    rd(12'hFCF, 8'h80);
    wr(12'hFCF, 8'h00);
    chk("master_irq_gate", 1'b0, master_irq_gate);
    for (int k = 2; k < 5; k++) begin
      pi(0);
      chk("master_irq_gate", 1'b1, master_irq_gate);
      pi(k);
      chk("master_irq_gate", 1'b0, master_irq_gate);
    end
  endtask
  task automatic t_wdt();
    src(8'h01, 4'h0);
    wdt_irq <= 1'b1;
    svc(16'h0004);
    wdt_irq <= 1'b0;
    svc(16'h0016);
    rd(12'hFC0, 8'h08);
  endtask
  ////////////////////////////////////////
  initial begin
    {resetn, reg_wr, reg_rd, wdt_irq, ins, reg_addr, reg_wdata, ack_dly} = '0;
    {periph0_pulse, periph2_pulse, pin_port_a, pin_port_d, pin_port_c} = '0;
    {cyc, error_cnt, check_count} = '0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_poll();
    t_prio();
    t_pins();
    t_gate();
    t_wdt();
    close_out();
  end
endmodule
